// [idmm_pkg.sv]
/*
 * Package for the internal data memory map: addressing modes, region
 * codes, status word bit positions, carriers for access requests.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package idmm_pkg;
  localparam int unsigned RAM_AW = 8;
  localparam logic [7:0] LOWER_TOP = 8'h7f;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [7:0] BITRAM_BASE = 8'h20;
  localparam int unsigned BANK_COUNT = 4;
  localparam int unsigned BANK_REGS = 8;
  localparam logic [7:0] SKIP_OPCODE = 8'ha5;
  localparam logic [7:0] PSW_ADDR = 8'hd0;
  localparam logic [7:0] ACC_ADDR = 8'he0;
  localparam logic [7:0] SP_ADDR = 8'h81;
  localparam logic [7:0] DPL_ADDR = 8'h82;
  localparam logic [7:0] DPH_ADDR = 8'h83;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [7:0] SP_RESET = 8'h07;
  // Status word bit positions
  localparam int unsigned PSW_CY = 7;
  localparam int unsigned PSW_AC = 6;
  localparam int unsigned PSW_F0 = 5;
  localparam int unsigned PSW_BSH = 4;
  localparam int unsigned PSW_BSL = 3;
  localparam int unsigned PSW_OV = 2;
  localparam int unsigned PSW_F1 = 1;
  localparam int unsigned PSW_P = 0;

  typedef enum logic [3:0] {
    IDMM_MODE_DIRECT = 4'b0001,
    IDMM_MODE_INDIRECT = 4'b0010,
    IDMM_MODE_REGISTER = 4'b0100,
    IDMM_MODE_BIT = 4'b1000
  } idmm_mode_t;

  typedef enum logic [1:0] {
    IDMM_PTR_R0 = 2'h0,
    IDMM_PTR_R1 = 2'h1,
    IDMM_PTR_SP = 2'h2
  } idmm_ptr_t;

  typedef enum logic [3:0] {
    IDMM_ST_IDLE = 4'b0001,
    IDMM_ST_PTR = 4'b0010,
    IDMM_ST_ACCESS = 4'b0100,
    IDMM_ST_DONE = 4'b1000
  } idmm_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    idmm_mode_t mode;
    idmm_ptr_t ptr_sel;
    logic [7:0] field;
    logic [7:0] wdata;
    logic bit_val;
  } idmm_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
    logic bit_val;
    logic unmapped;
  } idmm_rsp_t;

  typedef struct packed {
    logic [15:0] addr;
    logic wide;
    logic write;
    logic [7:0] wdata;
  } idmm_xreq_t;
endpackage : idmm_pkg

// [idmm_ram.sv]
/*
 * Single-port byte RAM with registered read data.
 * Assumes one clock; depth set by the address width.
 */
`timescale 1ns/1ps
module idmm_ram #(
  parameter int unsigned AW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : idmm_ram

// [idmm_xmem.sv]
/*
 * External data memory strobe sequencer: address phase on the
 * multiplexed port, then a read or write strobe.
 * Assumes the external RAM answers within the strobe phase.
 */
`timescale 1ns/1ps
module idmm_xmem
  import idmm_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire idmm_pkg::idmm_xreq_t xreq,
  input wire logic [7:0] port0_in,
  output logic [7:0] port0_out,
  output logic port0_oe,
  output logic [7:0] port2_out,
  output logic port2_oe,
  output logic addr_latch,
  output logic rd_n,
  output logic wr_n,
  output logic busy,
  output logic done,
  output logic [7:0] rdata
);
  logic [1:0] phase;
  idmm_xreq_t held;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      phase <= 2'h0;
      held <= '0;
    end else if (phase == 2'h0 && start) begin
      phase <= 2'h1;
      held <= xreq;
    end else if (phase != 2'h0) begin
      phase <= phase + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      port0_out <= 8'h00;
      port0_oe <= 1'b0;
      port2_out <= 8'h00;
      port2_oe <= 1'b0;
      addr_latch <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      done <= 1'b0;
      rdata <= 8'h00;
    end else begin
      done <= 1'b0;
      case (phase)
        2'h1: begin
          // Low address byte on port 0, latched outside
          port0_out <= held.addr[7:0];
          port0_oe <= 1'b1;
          port2_out <= held.addr[15:8];
          port2_oe <= held.wide;
          addr_latch <= 1'b1;
        end
        2'h2: begin
          addr_latch <= 1'b0;
          port0_out <= held.wdata;
          port0_oe <= held.write;
          rd_n <= held.write;
          wr_n <= !held.write;
        end
        2'h3: begin
          rdata <= port0_in;
          rd_n <= 1'b1;
          wr_n <= 1'b1;
          port0_oe <= 1'b0;
          port2_oe <= 1'b0;
          done <= 1'b1;
        end
        default: begin
          addr_latch <= 1'b0;
        end
      endcase
    end
  end

  assign busy = (phase != 2'h0);
endmodule : idmm_xmem

// [idmm_map.sv]
/*
 * Internal data memory map: lower and upper RAM, a few core special
 * function registers, bit access, status word and external data path.
 * Assumes the execution unit holds a request until it sees rsp.valid,
 * and that other special function registers live outside this block.
 */
// What this block does
// - Above 7FH: direct to SPECIAL_FUNCTION_SPACE, indirect upper RAM
// - Lowest 32 bytes are four eight-register banks
// - Status word bank bits pick the bank
// - Bytes 20H-2FH give bit addresses 00H-7FH
// - Lower 128 reachable direct and indirect
// - Upper 128 indirect only; absent on small variant
// - Special function registers direct only
// - SPECIAL_FUNCTION_SPACE addresses ending 0 or 8 bit-addressable
// - Parity flag tracks accumulator odd ones
// - Status word holds its flags in SPECIAL_FUNCTION_SPACE space
// - Carry is the Boolean accumulator
// - Direct uses 8-bit field, lower RAM or SPECIAL_FUNCTION_SPACE
// - Pointers: bank reg zero/one, stack
// - 3-bit field picks register in selected bank
// - External up to 64K, one or two bytes
// - Port 0 multiplexed, read/write strobes
// - Opcode A5H is a skip on base variants
`timescale 1ns/1ps
module idmm_map
  import idmm_pkg::*;
#(
  parameter bit HAS_UPPER = 1'b1,
  parameter bit BASE_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire idmm_pkg::idmm_req_t req,
  output idmm_pkg::idmm_rsp_t rsp,
  input wire logic [7:0] opcode,
  input wire logic opcode_valid,
  output logic opcode_skip,
  input wire logic alu_flags_we,
  input wire logic alu_cy,
  input wire logic alu_ac,
  input wire logic alu_ov,
  input wire logic bool_we,
  input wire logic bool_val,
  input wire logic acc_we,
  input wire logic [7:0] acc_wdata,
  input wire logic xreq_start,
  input wire idmm_pkg::idmm_xreq_t xreq,
  output logic xmem_busy,
  output logic xmem_done,
  output logic [7:0] xmem_rdata,
  input wire logic [7:0] port0_in,
  output logic [7:0] port0_out,
  output logic port0_oe,
  output logic [7:0] port2_out,
  output logic port2_oe,
  output logic addr_latch,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] program_status_word,
  output logic [7:0] accumulator,
  output logic [7:0] stack_pointer,
  output logic [15:0] data_pointer_16,
  output logic [1:0] bank_sel
);
  idmm_state_t state;
  idmm_req_t cur;
  logic [7:0] ptr_val;
  logic [7:0] eff_addr;
  logic to_sfr;
  logic is_bit;
  logic [2:0] bit_idx;
  logic bad;
  logic ram_we;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic [7:0] ram_addr;
  logic [7:0] psw_q;
  logic bank_select_high;
  logic bank_select_low;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  logic [7:0] byte_addr;
  logic [7:0] rd_byte;
  logic [7:0] next_byte;
  logic ram_phase;

  assign bank_select_high = psw_q[PSW_BSH];
  assign bank_select_low = psw_q[PSW_BSL];
  assign bank_sel = {bank_select_high, bank_select_low};

  // Parity is never stored: always a live function of the accumulator
  assign program_status_word = {psw_q[7:1], ^accumulator};

  // Bit address to byte address: low half in RAM 20H-2FH, high in SPECIAL_FUNCTION_SPACE
  always_comb begin
    if (cur.field[7]) begin
      byte_addr = {cur.field[7:3], 3'h0};
    end else begin
      byte_addr = BITRAM_BASE + {4'h0, cur.field[6:3]};
    end
  end

  // Pointer for indirect mode: stack pointer, or bank register read from RAM
  always_comb begin
    if (cur.ptr_sel == IDMM_PTR_SP) begin
      ptr_val = stack_pointer;
    end else if (state == IDMM_ST_PTR) begin
      ptr_val = ram_rdata;
    end else begin
      // Pointer already latched; RAM output now holds the target
      ptr_val = cur.field;
    end
  end

  always_comb begin
    to_sfr = 1'b0;
    is_bit = 1'b0;
    bad = 1'b0;
    eff_addr = cur.field;
    case (cur.mode)
      IDMM_MODE_DIRECT: begin
        // Direct: 8-bit field, upper half is SPECIAL_FUNCTION_SPACE space
        to_sfr = cur.field > LOWER_TOP;
      end
      IDMM_MODE_INDIRECT: begin
        // Indirect upper half reaches the separate upper RAM
        eff_addr = ptr_val;
        bad = (ptr_val >= UPPER_BASE) && !HAS_UPPER;
      end
      IDMM_MODE_REGISTER: begin
        eff_addr = {3'h0, bank_sel, cur.field[2:0]};
      end
      IDMM_MODE_BIT: begin
        is_bit = 1'b1;
        eff_addr = byte_addr;
        to_sfr = cur.field[7];
      end
      default: begin
        bad = 1'b1;
      end
    endcase
  end

  // Address fed to RAM: pointer fetch first, then the target byte
  always_comb begin
    if (state == IDMM_ST_IDLE && req.valid) begin
      if (req.mode == IDMM_MODE_INDIRECT && req.ptr_sel != IDMM_PTR_SP) begin
        ram_addr = {3'h0, bank_sel, 2'h0, req.ptr_sel[0]};
      end else begin
        ram_addr = 8'h00;
      end
    end else begin
      ram_addr = eff_addr;
    end
  end

  always_comb begin
    sfr_hit = 1'b1;
    if (eff_addr == PSW_ADDR) begin
      sfr_rdata = program_status_word;
    end else if (eff_addr == ACC_ADDR) begin
      sfr_rdata = accumulator;
    end else if (eff_addr == SP_ADDR) begin
      sfr_rdata = stack_pointer;
    end else if (eff_addr == DPL_ADDR) begin
      sfr_rdata = data_pointer_16[7:0];
    end else if (eff_addr == DPH_ADDR) begin
      sfr_rdata = data_pointer_16[15:8];
    end else begin
      sfr_rdata = 8'h00;
      sfr_hit = 1'b0;
    end
  end

  assign rd_byte = to_sfr ? sfr_rdata : ram_rdata;

  always_comb begin
    next_byte = cur.wdata;
    if (is_bit) begin
      next_byte = rd_byte;
      next_byte[cur.field[2:0]] = cur.bit_val;
    end
  end
  assign bit_idx = cur.field[2:0];

  assign ram_we = (state == IDMM_ST_ACCESS) && ram_phase && cur.write && !to_sfr && !bad;
  assign ram_wdata = next_byte;

  idmm_ram #(
    .AW(RAM_AW)
  ) u_ram (
    .clk(clk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  // Request sequencing
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= IDMM_ST_IDLE;
      cur <= '0;
      ram_phase <= 1'b0;
    end else begin
      case (state)
        IDMM_ST_IDLE: begin
          if (req.valid) begin
            cur <= req;
            ram_phase <= 1'b0;
            if (req.mode == IDMM_MODE_INDIRECT && req.ptr_sel != IDMM_PTR_SP) begin
              state <= IDMM_ST_PTR;
            end else begin
              state <= IDMM_ST_ACCESS;
            end
          end
        end
        IDMM_ST_PTR: begin
          // Latch the pointer so the target read does not lose it
          cur.field <= ram_rdata;
          state <= IDMM_ST_ACCESS;
        end
        IDMM_ST_ACCESS: begin
          if (ram_phase) begin
            state <= IDMM_ST_DONE;
          end
          ram_phase <= 1'b1;
        end
        IDMM_ST_DONE: begin
          state <= IDMM_ST_IDLE;
        end
        default: begin
          state <= IDMM_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rsp <= '0;
    end else begin
      rsp.valid <= (state == IDMM_ST_ACCESS) && ram_phase;
      if (state == IDMM_ST_ACCESS && ram_phase) begin
        rsp.rdata <= rd_byte;
        rsp.bit_val <= rd_byte[bit_idx];
        rsp.unmapped <= bad || (to_sfr && !sfr_hit);
      end
    end
  end

  // Status word: SPECIAL_FUNCTION_SPACE write, then ALU flags, Boolean carry has last say
  always_ff @(posedge clk) begin
    if (!rstn) begin
      psw_q <= PSW_RESET;
    end else begin
      if (ram_phase && state == IDMM_ST_ACCESS && cur.write && to_sfr &&
          eff_addr == PSW_ADDR) begin
        psw_q <= next_byte;
      end
      if (alu_flags_we) begin
        psw_q[PSW_CY] <= alu_cy;
        psw_q[PSW_AC] <= alu_ac;
        psw_q[PSW_OV] <= alu_ov;
      end
      if (bool_we) begin
        psw_q[PSW_CY] <= bool_val;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      accumulator <= 8'h00;
      stack_pointer <= SP_RESET;
      data_pointer_16 <= 16'h0000;
    end else begin
      if (acc_we) begin
        accumulator <= acc_wdata;
      end else if (ram_phase && state == IDMM_ST_ACCESS && cur.write && to_sfr) begin
        if (eff_addr == ACC_ADDR) begin
          accumulator <= next_byte;
        end else if (eff_addr == SP_ADDR) begin
          stack_pointer <= next_byte;
        end else if (eff_addr == DPL_ADDR) begin
          data_pointer_16[7:0] <= next_byte;
        end else if (eff_addr == DPH_ADDR) begin
          data_pointer_16[15:8] <= next_byte;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      opcode_skip <= 1'b0;
    end else begin
      opcode_skip <= opcode_valid && BASE_VARIANT && (opcode == SKIP_OPCODE);
    end
  end

  idmm_xmem u_xmem (
    .clk(clk),
    .rstn(rstn),
    .start(xreq_start),
    .xreq(xreq),
    .port0_in(port0_in),
    .port0_out(port0_out),
    .port0_oe(port0_oe),
    .port2_out(port2_out),
    .port2_oe(port2_oe),
    .addr_latch(addr_latch),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .busy(xmem_busy),
    .done(xmem_done),
    .rdata(xmem_rdata)
  );
endmodule : idmm_map

// [idmm_map_sva.sv]
/*
 * Checker for idmm_map: status word, skip opcode, answer timing and
 * external strobe phases. Assumes it is bound to idmm_map.
 */
`timescale 1ns/1ps
module idmm_map_sva
  import idmm_pkg::*;
#(
  parameter bit HAS_UPPER = 1'b1,
  parameter bit BASE_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire idmm_pkg::idmm_req_t req,
  input wire idmm_pkg::idmm_rsp_t rsp,
  input wire logic [7:0] opcode,
  input wire logic opcode_valid,
  input wire logic opcode_skip,
  input wire logic alu_flags_we,
  input wire logic alu_ac,
  input wire logic alu_ov,
  input wire logic bool_we,
  input wire logic bool_val,
  input wire logic xreq_start,
  input wire idmm_pkg::idmm_xreq_t xreq,
  input wire logic xmem_busy,
  input wire logic xmem_done,
  input wire logic [7:0] port0_out,
  input wire logic port0_oe,
  input wire logic [7:0] port2_out,
  input wire logic port2_oe,
  input wire logic addr_latch,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] program_status_word,
  input wire logic [7:0] accumulator,
  input wire logic [1:0] bank_sel
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_addr;
    addr_latch && port0_oe;
  endsequence
  sequence s_strobe;
    !addr_latch && (rd_n != wr_n);
  endsequence
  sequence s_end;
    rd_n && wr_n && xmem_done && !port0_oe;
  endsequence
  property p_xfer;
    xreq_start && !xmem_busy |=> ##1 s_addr ##1 s_strobe ##1 s_end;
  endproperty
  a_xfer: assert property (p_xfer) else $error("external phases wrong");
  property p_wdata;
    xreq_start && !xmem_busy && xreq.write |=> ##2 !wr_n && port0_oe
      && port0_out == $past(xreq.wdata, 3);
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data wrong");
  property p_addr;
    xreq_start && !xmem_busy |=> ##1 port0_out == $past(xreq.addr[7:0], 2)
      && port2_oe == $past(xreq.wide, 2)
      && (!port2_oe || port2_out == $past(xreq.addr[15:8], 2));
  endproperty
  a_addr: assert property (p_addr) else $error("address phase wrong");
  property p_rdfloat;
    !rd_n |-> !port0_oe;
  endproperty
  a_rdfloat: assert property (p_rdfloat) else $error("port driven in read");
  property p_par;
    program_status_word[PSW_P] == ^accumulator;
  endproperty
  a_par: assert property (p_par) else $error("parity flag wrong");
  property p_bank;
    bank_sel == program_status_word[PSW_BSH:PSW_BSL];
  endproperty
  a_bank: assert property (p_bank) else $error("bank select wrong");
  property p_bool;
    bool_we |=> program_status_word[PSW_CY] == $past(bool_val);
  endproperty
  a_bool: assert property (p_bool) else $error("carry write wrong");
  property p_alu;
    alu_flags_we |=> program_status_word[PSW_AC] == $past(alu_ac)
      && program_status_word[PSW_OV] == $past(alu_ov);
  endproperty
  a_alu: assert property (p_alu) else $error("flag positions wrong");
  property p_skip;
    opcode_valid && opcode == SKIP_OPCODE |=> opcode_skip == BASE_VARIANT;
  endproperty
  a_skip: assert property (p_skip) else $error("skip opcode wrong");
  property p_rsp;
    $rose(req.valid) |-> ##[3:4] rsp.valid ##1 !rsp.valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("answer timing wrong");
endmodule : idmm_map_sva

bind idmm_map idmm_map_sva #(.HAS_UPPER(HAS_UPPER), .BASE_VARIANT(BASE_VARIANT)) i_idmm_map_sva (
  .clk, .rstn, .req, .rsp, .opcode, .opcode_valid, .opcode_skip, .alu_flags_we, .alu_ac,
  .alu_ov, .bool_we, .bool_val, .xreq_start, .xreq, .xmem_busy, .xmem_done, .port0_out,
  .port0_oe, .port2_out, .port2_oe, .addr_latch, .rd_n, .wr_n, .program_status_word,
  .accumulator, .bank_sel
);

// [idmm_xram.sv]
/*
 * External data RAM model on the multiplexed port.
 * Assumes the device clock and no pull-ups on port 0.
 */
`timescale 1ns/1ps
module idmm_xram (
  input wire logic clk,
  input wire logic [7:0] port0_out,
  input wire logic port0_oe,
  input wire logic [7:0] port2_out,
  input wire logic port2_oe,
  input wire logic addr_latch,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic [7:0] port0_in
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr = 16'h0000;
  logic [7:0] last = 8'h00;
  always @(posedge clk) begin
    if (addr_latch) begin
      addr <= {port2_oe ? port2_out : 8'h00, port0_out};
    end
    if (!wr_n) begin
      mem[addr] <= port0_out;
    end
    if (!rd_n) begin
      last <= mem[addr];
    end
  end
  // Floating bus shows the inverse, so a stale byte never passes
  assign port0_in = port0_oe ? port0_out : (!rd_n ? mem[addr] : ~last);
endmodule : idmm_xram

// [tb_idmm_map.sv]
/*
 * Self-checking bench for idmm_map with random and corner accesses.
 * Assumes idmm_pkg, the bound checker and the external RAM model.
 */
`timescale 1ns/1ps
module tb_idmm_map;
  import idmm_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  idmm_req_t req = '0;
  idmm_rsp_t rsp;
  logic [7:0] opcode = 8'h00;
  logic opcode_valid = 1'b0;
  logic alu_flags_we = 1'b0;
  logic alu_cy = 1'b0;
  logic alu_ac = 1'b0;
  logic alu_ov = 1'b0;
  logic bool_we = 1'b0;
  logic bool_val = 1'b0;
  logic acc_we = 1'b0;
  logic [7:0] acc_wdata = 8'h00;
  logic xreq_start = 1'b0;
  idmm_xreq_t xreq = '0;
  logic opcode_skip, xmem_busy, xmem_done, port0_oe, port2_oe, addr_latch, rd_n, wr_n;
  logic [7:0] xmem_rdata, port0_in, port0_out, port2_out, program_status_word;
  logic [7:0] accumulator, stack_pointer;
  logic [15:0] data_pointer_16;
  logic [1:0] bank_sel;
  logic [31:0] seed = 32'd60;
  int n_mismatch = 0;
  int check_count = 0;
  idmm_map i_idmm_map (
    .clk, .rstn, .req, .rsp, .opcode, .opcode_valid, .opcode_skip, .alu_flags_we, .alu_cy,
    .alu_ac, .alu_ov, .bool_we, .bool_val, .acc_we, .acc_wdata, .xreq_start, .xreq,
    .xmem_busy, .xmem_done, .xmem_rdata, .port0_in, .port0_out, .port0_oe, .port2_out,
    .port2_oe, .addr_latch, .rd_n, .wr_n, .program_status_word, .accumulator,
    .stack_pointer, .data_pointer_16, .bank_sel
  );
  idmm_xram i_idmm_xram (
    .clk, .port0_out, .port0_oe, .port2_out, .port2_oe, .addr_latch, .rd_n, .wr_n, .port0_in
  );
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  function automatic logic [7:0] bank_addr(logic [1:0] b, logic [2:0] r);
    return {3'h0, b, r};
  endfunction : bank_addr
  function automatic logic [7:0] bit_byte(logic [7:0] ba);
    return BITRAM_BASE + {4'h0, ba[6:3]};
  endfunction : bit_byte
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // Valid drops at the edge that sees the answer, so it is not re-taken
  task automatic acc(idmm_mode_t m, logic w, logic [7:0] f, logic [7:0] d, idmm_ptr_t p);
    int i;
    @(posedge clk);
    req <= '{1'b1, w, m, p, f, d, d[0]};
    for (i = 1; i <= 8; i++) begin
      @(posedge clk);
      if (rsp.valid === 1'b1) break;
    end
    req.valid <= 1'b0;
    if (i > 8) begin
      n_mismatch++;
      final_report();
    end
    chk("rsp_latency", (m == IDMM_MODE_INDIRECT && p != IDMM_PTR_SP) ? 16'd5 : 16'd4,
        i[15:0]);
  endtask : acc
  task automatic xfer(logic [15:0] a, logic w, logic wr, logic [7:0] d);
    int i;
    @(posedge clk);
    xreq <= '{a, w, wr, d};
    xreq_start <= 1'b1;
    @(posedge clk);
    xreq_start <= 1'b0;
    for (i = 0; i < 8 && xmem_done !== 1'b1; i++) @(posedge clk);
    if (i == 8) begin
      n_mismatch++;
      final_report();
    end
    @(posedge clk);
  endtask : xfer
  initial begin
    int b;
    logic [7:0] r, d, a;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    chk("psw", {8'h0, PSW_RESET}, {8'h0, program_status_word});
    chk("sp", {8'h0, SP_RESET}, {8'h0, stack_pointer});
    chk("data_pointer_16", 16'h0000, data_pointer_16);
    chk("strobes", 16'h0003, {14'h0, rd_n, wr_n});
    for (b = 0; b < 4; b++) begin
      r = rnd();
      d = rnd();
      a = 8'h40 | (rnd() & 8'h3f);
      acc(IDMM_MODE_DIRECT, 1'b1, PSW_ADDR, {3'h0, b[1:0], 3'h0}, IDMM_PTR_R0);
      acc(IDMM_MODE_REGISTER, 1'b1, {5'h00, r[2:0]}, d, IDMM_PTR_R0);
      acc(IDMM_MODE_DIRECT, 1'b0, bank_addr(b[1:0], r[2:0]), 8'h00, IDMM_PTR_R0);
      chk("bank_reg", {8'h0, d}, {8'h0, rsp.rdata});
      d = rnd();
      acc(IDMM_MODE_REGISTER, 1'b1, {7'h00, b[0]}, a, IDMM_PTR_R0);
      acc(IDMM_MODE_DIRECT, 1'b1, a, d, IDMM_PTR_R0);
      acc(IDMM_MODE_INDIRECT, 1'b0, 8'h00, 8'h00, idmm_ptr_t'({1'b0, b[0]}));
      chk("ind_lower", {8'h0, d}, {8'h0, rsp.rdata});
    end
    acc(IDMM_MODE_DIRECT, 1'b1, 8'h07, d, IDMM_PTR_R0);
    acc(IDMM_MODE_INDIRECT, 1'b0, 8'h00, 8'h00, IDMM_PTR_SP);
    chk("ind_sp", {8'h0, d}, {8'h0, rsp.rdata});
    $display("bank test done");
    d = rnd();
    r = ~d;
    acc(IDMM_MODE_REGISTER, 1'b1, 8'h01, ACC_ADDR, IDMM_PTR_R0);
    acc(IDMM_MODE_DIRECT, 1'b1, ACC_ADDR, d, IDMM_PTR_R0);
    acc(IDMM_MODE_INDIRECT, 1'b1, 8'h00, r, IDMM_PTR_R1);
    chk("acc", {8'h0, d}, {8'h0, accumulator});
    acc(IDMM_MODE_INDIRECT, 1'b0, 8'h00, 8'h00, IDMM_PTR_R1);
    chk("upper", {8'h0, r}, {8'h0, rsp.rdata});
    acc(IDMM_MODE_DIRECT, 1'b0, 8'h90, 8'h00, IDMM_PTR_R0);
    chk("sfr_unmapped", 16'h0001, {15'h0, rsp.unmapped});
    for (b = 0; b < 4; b++) begin
      r = rnd() & 8'h7f;
      acc(IDMM_MODE_DIRECT, 1'b1, bit_byte(r), 8'h00, IDMM_PTR_R0);
      acc(IDMM_MODE_BIT, 1'b1, r, 8'h01, IDMM_PTR_R0);
      acc(IDMM_MODE_DIRECT, 1'b0, bit_byte(r), 8'h00, IDMM_PTR_R0);
      chk("bit_ram", {8'h0, 8'h01 << r[2:0]}, {8'h0, rsp.rdata});
    end
    acc(IDMM_MODE_BIT, 1'b1, PSW_ADDR + 8'h05, 8'h01, IDMM_PTR_R0);
    chk("psw_user", 16'h0001, {15'h0, program_status_word[PSW_F0]});
    $display("map test done");
    for (b = 0; b < 2; b++) begin
      d = rnd();
      @(posedge clk);
      {bool_we, alu_flags_we, acc_we, opcode_valid} <= 4'hf;
      {bool_val, alu_cy, alu_ac, alu_ov} <= {b[0], ~b[0], b[0], ~b[0]};
      acc_wdata <= d;
      opcode <= SKIP_OPCODE;
      @(posedge clk);
      {bool_we, alu_flags_we, acc_we, opcode_valid} <= 4'h0;
      @(posedge clk);
      chk("carry", {15'h0, b[0]}, {15'h0, program_status_word[PSW_CY]});
      chk("acc_par", {7'h0, ^d, d}, {7'h0, program_status_word[PSW_P], accumulator});
      chk("skip", 16'h0000, {15'h0, opcode_skip});
    end
    $display("flag test done");
    a = rnd() | 8'h01;
    d = rnd();
    r = ~d;
    xfer({a, 8'h5a}, 1'b1, 1'b1, d);
    xfer(16'h005a, 1'b0, 1'b1, r);
    xfer({a, 8'h5a}, 1'b1, 1'b0, 8'h00);
    chk("xram_wide", {8'h0, d}, {8'h0, xmem_rdata});
    xfer(16'h005a, 1'b0, 1'b0, 8'h00);
    chk("xram_narrow", {8'h0, r}, {8'h0, xmem_rdata});
    $display("external test done");
    final_report();
  end
endmodule : tb_idmm_map
